// ### shared/ctp_pkg.sv
// constants and types shared by the complementary three-phase pwm generator
package ctp_pkg;
	// register indices on the register access port
	localparam logic [3:0] IDX_UPPER_LIMIT_COMPARE = 4'h0;
	localparam logic [3:0] IDX_PHASE1_DUTY_COMPARE = 4'h1;
	localparam logic [3:0] IDX_UPPER_LIMIT_BUFFER = 4'h2;
	localparam logic [3:0] IDX_PHASE1_DUTY_BUFFER = 4'h3;
	localparam logic [3:0] IDX_PHASE2_DUTY_COMPARE = 4'h4;
	localparam logic [3:0] IDX_PHASE3_DUTY_COMPARE = 4'h5;
	localparam logic [3:0] IDX_PHASE2_DUTY_BUFFER = 4'h6;
	localparam logic [3:0] IDX_PHASE3_DUTY_BUFFER = 4'h7;
	localparam logic [3:0] IDX_UPPER_COUNTER = 4'h8;
	localparam logic [3:0] IDX_LOWER_COUNTER = 4'h9;
	localparam logic [3:0] IDX_DEAD_TIME_VALUE = 4'ha;
	localparam logic [3:0] IDX_HALF_CYCLE_VALUE = 4'hb;
	localparam logic [3:0] IDX_HALF_CYCLE_BUFFER = 4'hc;

	// reset values and the lower counter turning point
	localparam logic [15:0] RST_REG = 16'hffff;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] LOWER_TURN = 16'h0000;
	localparam logic SYNC_TOGGLE_INIT = 1'b1;

	// counter clock selections
	localparam logic [2:0] CLK_DIV1 = 3'h0;
	localparam logic [2:0] CLK_DIV4 = 3'h1;
	localparam logic [2:0] CLK_DIV16 = 3'h2;
	localparam logic [2:0] CLK_DIV64 = 3'h3;
	localparam logic [2:0] CLK_DIV256 = 3'h4;
	localparam logic [2:0] CLK_DIV1024 = 3'h5;
	localparam logic [2:0] CLK_EXT0 = 3'h6;
	localparam logic [2:0] CLK_EXT1 = 3'h7;

	// sequencer states, gray coded along idle, load, run
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b11
	} ctp_state_t;
endpackage

// ### verilog/ctp_pwm.sv
// complementary three-phase pwm generator with dead time and carrier sync toggle
`timescale 1ns/100ps
module ctp_pwm (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register access port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// control
	input wire logic run_en,
	input wire logic dead_time_en,
	input wire logic positive_level_select,
	input wire logic negative_level_select,
	input wire logic carrier_sync_en,
	input wire logic [2:0] clock_select,
	input wire logic [2:0] event_skip,
	// external clock pins
	input wire logic [1:0] external_clock_in,
	// events
	output logic crest_event,
	output logic trough_event,
	output logic crest_adc_trigger,
	output logic trough_adc_trigger,
	output logic running,
	// pwm pins
	output logic carrier_sync_toggle_out,
	output logic phase1_positive_out,
	output logic phase1_inverse_out,
	output logic phase2_positive_out,
	output logic phase2_inverse_out,
	output logic phase3_positive_out,
	output logic phase3_inverse_out
);
	// prescaler tick for a divider selection
	function automatic logic div_tick(input logic [9:0] pre, input logic [2:0] sel);
		case (sel)
			ctp_pkg::CLK_DIV1: div_tick = 1'b1;
			ctp_pkg::CLK_DIV4: div_tick = &pre[1:0];
			ctp_pkg::CLK_DIV16: div_tick = &pre[3:0];
			ctp_pkg::CLK_DIV64: div_tick = &pre[5:0];
			ctp_pkg::CLK_DIV256: div_tick = &pre[7:0];
			ctp_pkg::CLK_DIV1024: div_tick = &pre[9:0];
			default: div_tick = 1'b0;
		endcase
	endfunction

	// on decision for one pair: bit1 positive, bit0 inverse
	function automatic logic [1:0] pair_on(input logic [15:0] duty, input logic [15:0] lower,
			input logic [15:0] upper, input logic [15:0] limit, input logic gap);
		logic p;
		logic n;
		p = 1'b0;
		n = 1'b0;
		if (duty == 16'h0000) begin
			p = 1'b1;
			n = 1'b0;
		end else if (duty >= limit) begin
			p = 1'b0;
			n = 1'b1;
		end else if (gap) begin
			// positive waits for the lower counter, inverse for the upper one; the two
			// counters sit one dead time apart, so both lines are off while duty lies between
			p = (lower > duty);
			n = (upper < duty);
		end else begin
			p = (lower >= duty);
			n = ~p;
		end
		pair_on = {p, n};
	endfunction

	// state
	ctp_pkg::ctp_state_t state_ff, nxt_state;
	logic [9:0] pre_ff, nxt_pre;                 // prescaler
	logic [1:0] ext_s1_ff;                       // external clock first sync stage
	logic [1:0] ext_s2_ff;                       // second sync stage
	logic [1:0] ext_s3_ff;                       // edge history
	logic [15:0] upper_limit_compare_ff, nxt_upper_limit_compare;
	logic [15:0] upper_limit_buffer_ff, nxt_upper_limit_buffer;
	logic [15:0] phase1_duty_compare_ff, nxt_phase1_duty_compare;
	logic [15:0] phase2_duty_compare_ff, nxt_phase2_duty_compare;
	logic [15:0] phase3_duty_compare_ff, nxt_phase3_duty_compare;
	logic [15:0] phase1_duty_buffer_ff, nxt_phase1_duty_buffer;
	logic [15:0] phase2_duty_buffer_ff, nxt_phase2_duty_buffer;
	logic [15:0] phase3_duty_buffer_ff, nxt_phase3_duty_buffer;
	logic [15:0] duty_transfer_temp_ff [3];      // hidden from the register port
	logic [15:0] nxt_duty_transfer_temp [3];
	logic [15:0] upper_counter_ff, nxt_upper_counter;
	logic [15:0] lower_counter_ff, nxt_lower_counter;
	logic upper_down_ff, nxt_upper_down;         // first counter direction
	logic lower_down_ff, nxt_lower_down;         // second counter direction
	logic [15:0] dead_time_value_ff, nxt_dead_time_value;
	logic [15:0] half_cycle_value_ff, nxt_half_cycle_value;
	logic [15:0] half_cycle_buffer_ff, nxt_half_cycle_buffer;
	logic [2:0] crest_skip_ff, nxt_crest_skip;
	logic [2:0] trough_skip_ff, nxt_trough_skip;
	logic crest_event_ff, nxt_crest_event;
	logic trough_event_ff, nxt_trough_event;
	logic sync_ff, nxt_sync;
	logic [5:0] pwm_ff, nxt_pwm;                 // p1 n1 p2 n2 p3 n3
	logic [15:0] rdata_ff, nxt_rdata;
	logic tick;                                  // counter clock enable
	logic ext_rise0;
	logic ext_rise1;
	logic crest;
	logic trough;
	logic run_now;
	logic [1:0] on1;
	logic [1:0] on2;
	logic [1:0] on3;

	// external clock edges, read only from the second sync stage onward
	assign ext_rise0 = ext_s2_ff[0] & ~ext_s3_ff[0];
	assign ext_rise1 = ext_s2_ff[1] & ~ext_s3_ff[1];

	// counter clock source mux
	always_comb begin
		case (clock_select)
			ctp_pkg::CLK_EXT0: tick = ext_rise0;
			ctp_pkg::CLK_EXT1: tick = ext_rise1;
			default: tick = div_tick(pre_ff, clock_select);
		endcase
	end

	assign run_now = (state_ff == ctp_pkg::ST_RUN);
	// turning points; both counters share one clock so they turn together
	assign crest = run_now & tick & ~upper_down_ff & (upper_counter_ff == upper_limit_compare_ff);
	assign trough = run_now & tick & lower_down_ff & (lower_counter_ff == ctp_pkg::LOWER_TURN);

	// per-pair on decisions
	assign on1 = pair_on(phase1_duty_compare_ff, lower_counter_ff, upper_counter_ff,
		upper_limit_compare_ff, dead_time_en);
	assign on2 = pair_on(phase2_duty_compare_ff, lower_counter_ff, upper_counter_ff,
		upper_limit_compare_ff, dead_time_en);
	assign on3 = pair_on(phase3_duty_compare_ff, lower_counter_ff, upper_counter_ff,
		upper_limit_compare_ff, dead_time_en);

	// next-state logic for sequencer, registers, counters and outputs
	always_comb begin
		nxt_state = state_ff;
		nxt_pre = pre_ff + 10'h001;
		nxt_upper_limit_compare = upper_limit_compare_ff;
		nxt_upper_limit_buffer = upper_limit_buffer_ff;
		nxt_phase1_duty_compare = phase1_duty_compare_ff;
		nxt_phase2_duty_compare = phase2_duty_compare_ff;
		nxt_phase3_duty_compare = phase3_duty_compare_ff;
		nxt_phase1_duty_buffer = phase1_duty_buffer_ff;
		nxt_phase2_duty_buffer = phase2_duty_buffer_ff;
		nxt_phase3_duty_buffer = phase3_duty_buffer_ff;
		nxt_duty_transfer_temp = duty_transfer_temp_ff;
		nxt_upper_counter = upper_counter_ff;
		nxt_lower_counter = lower_counter_ff;
		nxt_upper_down = upper_down_ff;
		nxt_lower_down = lower_down_ff;
		nxt_dead_time_value = dead_time_value_ff;
		nxt_half_cycle_value = half_cycle_value_ff;
		nxt_half_cycle_buffer = half_cycle_buffer_ff;
		nxt_crest_skip = crest_skip_ff;
		nxt_trough_skip = trough_skip_ff;
		nxt_crest_event = 1'b0;
		nxt_trough_event = 1'b0;
		nxt_sync = sync_ff;
		nxt_rdata = rdata_ff;

		// register writes; compares and counters are direct only while stopped
		if (reg_wr) begin
			case (reg_addr)
				ctp_pkg::IDX_UPPER_LIMIT_COMPARE:
					if (!run_now) nxt_upper_limit_compare = reg_wdata;
				ctp_pkg::IDX_PHASE1_DUTY_COMPARE:
					if (!run_now) nxt_phase1_duty_compare = reg_wdata;
				ctp_pkg::IDX_PHASE2_DUTY_COMPARE:
					if (!run_now) nxt_phase2_duty_compare = reg_wdata;
				ctp_pkg::IDX_PHASE3_DUTY_COMPARE:
					if (!run_now) nxt_phase3_duty_compare = reg_wdata;
				ctp_pkg::IDX_UPPER_LIMIT_BUFFER: nxt_upper_limit_buffer = reg_wdata;
				ctp_pkg::IDX_PHASE1_DUTY_BUFFER: nxt_phase1_duty_buffer = reg_wdata;
				ctp_pkg::IDX_PHASE2_DUTY_BUFFER: nxt_phase2_duty_buffer = reg_wdata;
				ctp_pkg::IDX_PHASE3_DUTY_BUFFER: begin
					// phase three is written last, so it commits all three to the temps
					nxt_phase3_duty_buffer = reg_wdata;
					nxt_duty_transfer_temp[0] = phase1_duty_buffer_ff;
					nxt_duty_transfer_temp[1] = phase2_duty_buffer_ff;
					nxt_duty_transfer_temp[2] = reg_wdata;
				end
				ctp_pkg::IDX_UPPER_COUNTER:
					if (state_ff == ctp_pkg::ST_IDLE) nxt_upper_counter = reg_wdata;
				ctp_pkg::IDX_LOWER_COUNTER:
					if (state_ff == ctp_pkg::ST_IDLE) nxt_lower_counter = reg_wdata;
				ctp_pkg::IDX_DEAD_TIME_VALUE: nxt_dead_time_value = reg_wdata;
				ctp_pkg::IDX_HALF_CYCLE_VALUE:
					if (!run_now) nxt_half_cycle_value = reg_wdata;
				ctp_pkg::IDX_HALF_CYCLE_BUFFER: nxt_half_cycle_buffer = reg_wdata;
				default: ;
			endcase
		end

		// register reads; unmapped indices and the temporaries read zero
		if (reg_rd) begin
			case (reg_addr)
				ctp_pkg::IDX_UPPER_LIMIT_COMPARE: nxt_rdata = upper_limit_compare_ff;
				ctp_pkg::IDX_PHASE1_DUTY_COMPARE: nxt_rdata = phase1_duty_compare_ff;
				ctp_pkg::IDX_UPPER_LIMIT_BUFFER: nxt_rdata = upper_limit_buffer_ff;
				ctp_pkg::IDX_PHASE1_DUTY_BUFFER: nxt_rdata = phase1_duty_buffer_ff;
				ctp_pkg::IDX_PHASE2_DUTY_COMPARE: nxt_rdata = phase2_duty_compare_ff;
				ctp_pkg::IDX_PHASE3_DUTY_COMPARE: nxt_rdata = phase3_duty_compare_ff;
				ctp_pkg::IDX_PHASE2_DUTY_BUFFER: nxt_rdata = phase2_duty_buffer_ff;
				ctp_pkg::IDX_PHASE3_DUTY_BUFFER: nxt_rdata = phase3_duty_buffer_ff;
				ctp_pkg::IDX_UPPER_COUNTER: nxt_rdata = upper_counter_ff;
				ctp_pkg::IDX_LOWER_COUNTER: nxt_rdata = lower_counter_ff;
				ctp_pkg::IDX_DEAD_TIME_VALUE: nxt_rdata = dead_time_value_ff;
				ctp_pkg::IDX_HALF_CYCLE_VALUE: nxt_rdata = half_cycle_value_ff;
				ctp_pkg::IDX_HALF_CYCLE_BUFFER: nxt_rdata = half_cycle_buffer_ff;
				default: nxt_rdata = 16'h0000;
			endcase
		end

		// sequencer
		case (state_ff)
			ctp_pkg::ST_IDLE: if (run_en) nxt_state = ctp_pkg::ST_LOAD;
			ctp_pkg::ST_LOAD: begin
				// preload both counters so they start in step on the same edge
				nxt_upper_counter = dead_time_value_ff;
				nxt_lower_counter = ctp_pkg::LOWER_TURN;
				nxt_upper_down = 1'b0;
				nxt_lower_down = 1'b0;
				nxt_sync = ctp_pkg::SYNC_TOGGLE_INIT;
				nxt_crest_skip = 3'h0;
				nxt_trough_skip = 3'h0;
				nxt_state = run_en ? ctp_pkg::ST_RUN : ctp_pkg::ST_IDLE;
			end
			ctp_pkg::ST_RUN: begin
				if (!run_en) nxt_state = ctp_pkg::ST_IDLE;
				if (tick) begin
					// first counter turns at the upper limit and at the dead time
					nxt_upper_down = upper_down_ff ? (upper_counter_ff != dead_time_value_ff)
						: (upper_counter_ff == upper_limit_compare_ff);
					nxt_upper_counter = nxt_upper_down ? upper_counter_ff - 16'h0001
						: upper_counter_ff + 16'h0001;
					// second counter turns at the half cycle and at zero
					nxt_lower_down = lower_down_ff ? (lower_counter_ff != ctp_pkg::LOWER_TURN)
						: (lower_counter_ff == half_cycle_value_ff);
					nxt_lower_counter = nxt_lower_down ? lower_counter_ff - 16'h0001
						: lower_counter_ff + 16'h0001;
				end
				// buffered transfers happen only at the turning points, never mid-slope
				if (crest || trough) begin
					nxt_upper_limit_compare = upper_limit_buffer_ff;
					nxt_half_cycle_value = half_cycle_buffer_ff;
					nxt_phase1_duty_compare = duty_transfer_temp_ff[0];
					nxt_phase2_duty_compare = duty_transfer_temp_ff[1];
					nxt_phase3_duty_compare = duty_transfer_temp_ff[2];
					if (carrier_sync_en) nxt_sync = ~sync_ff;
				end
				// skip counters pass one event in every event_skip+1
				if (crest) begin
					nxt_crest_event = (crest_skip_ff >= event_skip);
					nxt_crest_skip = nxt_crest_event ? 3'h0 : crest_skip_ff + 3'h1;
				end
				if (trough) begin
					nxt_trough_event = (trough_skip_ff >= event_skip);
					nxt_trough_skip = nxt_trough_event ? 3'h0 : trough_skip_ff + 3'h1;
				end
			end
			default: nxt_state = ctp_pkg::ST_IDLE;
		endcase

		// pin levels: on drives the select level, off its opposite
		if (run_now) begin
			nxt_pwm[5] = on1[1] ? positive_level_select : ~positive_level_select;
			nxt_pwm[4] = on1[0] ? negative_level_select : ~negative_level_select;
			nxt_pwm[3] = on2[1] ? positive_level_select : ~positive_level_select;
			nxt_pwm[2] = on2[0] ? negative_level_select : ~negative_level_select;
			nxt_pwm[1] = on3[1] ? positive_level_select : ~positive_level_select;
			nxt_pwm[0] = on3[0] ? negative_level_select : ~negative_level_select;
		end else begin
			// stopped: every line off, so no pair can short
			nxt_pwm = {~positive_level_select, ~negative_level_select,
				~positive_level_select, ~negative_level_select,
				~positive_level_select, ~negative_level_select};
		end
	end

	// register all state; reset loads constants only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= ctp_pkg::ST_IDLE;
			pre_ff <= 10'h000;
			ext_s1_ff <= 2'h0;
			ext_s2_ff <= 2'h0;
			ext_s3_ff <= 2'h0;
			upper_limit_compare_ff <= ctp_pkg::RST_REG;
			upper_limit_buffer_ff <= ctp_pkg::RST_REG;
			phase1_duty_compare_ff <= ctp_pkg::RST_REG;
			phase2_duty_compare_ff <= ctp_pkg::RST_REG;
			phase3_duty_compare_ff <= ctp_pkg::RST_REG;
			phase1_duty_buffer_ff <= ctp_pkg::RST_REG;
			phase2_duty_buffer_ff <= ctp_pkg::RST_REG;
			phase3_duty_buffer_ff <= ctp_pkg::RST_REG;
			duty_transfer_temp_ff[0] <= ctp_pkg::RST_REG;
			duty_transfer_temp_ff[1] <= ctp_pkg::RST_REG;
			duty_transfer_temp_ff[2] <= ctp_pkg::RST_REG;
			upper_counter_ff <= ctp_pkg::RST_COUNT;
			lower_counter_ff <= ctp_pkg::RST_COUNT;
			upper_down_ff <= 1'b0;
			lower_down_ff <= 1'b0;
			dead_time_value_ff <= ctp_pkg::RST_REG;
			half_cycle_value_ff <= ctp_pkg::RST_REG;
			half_cycle_buffer_ff <= ctp_pkg::RST_REG;
			crest_skip_ff <= 3'h0;
			trough_skip_ff <= 3'h0;
			crest_event_ff <= 1'b0;
			trough_event_ff <= 1'b0;
			sync_ff <= ctp_pkg::SYNC_TOGGLE_INIT;
			pwm_ff <= 6'h3f;
			rdata_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			pre_ff <= nxt_pre;
			ext_s1_ff <= external_clock_in;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
			upper_limit_compare_ff <= nxt_upper_limit_compare;
			upper_limit_buffer_ff <= nxt_upper_limit_buffer;
			phase1_duty_compare_ff <= nxt_phase1_duty_compare;
			phase2_duty_compare_ff <= nxt_phase2_duty_compare;
			phase3_duty_compare_ff <= nxt_phase3_duty_compare;
			phase1_duty_buffer_ff <= nxt_phase1_duty_buffer;
			phase2_duty_buffer_ff <= nxt_phase2_duty_buffer;
			phase3_duty_buffer_ff <= nxt_phase3_duty_buffer;
			duty_transfer_temp_ff <= nxt_duty_transfer_temp;
			upper_counter_ff <= nxt_upper_counter;
			lower_counter_ff <= nxt_lower_counter;
			upper_down_ff <= nxt_upper_down;
			lower_down_ff <= nxt_lower_down;
			dead_time_value_ff <= nxt_dead_time_value;
			half_cycle_value_ff <= nxt_half_cycle_value;
			half_cycle_buffer_ff <= nxt_half_cycle_buffer;
			crest_skip_ff <= nxt_crest_skip;
			trough_skip_ff <= nxt_trough_skip;
			crest_event_ff <= nxt_crest_event;
			trough_event_ff <= nxt_trough_event;
			sync_ff <= nxt_sync;
			pwm_ff <= nxt_pwm;
			rdata_ff <= nxt_rdata;
		end
	end

	// outputs straight from flip-flops, except running, decoded from state_ff
	assign reg_rdata = rdata_ff;
	assign crest_event = crest_event_ff;
	assign trough_event = trough_event_ff;
	assign crest_adc_trigger = crest_event_ff;
	assign trough_adc_trigger = trough_event_ff;
	assign running = run_now;
	assign carrier_sync_toggle_out = sync_ff;
	assign phase1_positive_out = pwm_ff[5];
	assign phase1_inverse_out = pwm_ff[4];
	assign phase2_positive_out = pwm_ff[3];
	assign phase2_inverse_out = pwm_ff[2];
	assign phase3_positive_out = pwm_ff[1];
	assign phase3_inverse_out = pwm_ff[0];
endmodule // ctp_pwm

// ### dv/ctp_pwm_chk.sv
// port-level assertions for the complementary three-phase pwm generator
`timescale 1ns/100ps
module ctp_pwm_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic run_en,
	input wire logic dead_time_en,
	input wire logic positive_level_select,
	input wire logic negative_level_select,
	input wire logic carrier_sync_en,
	// status
	input wire logic crest_event,
	input wire logic trough_event,
	input wire logic crest_adc_trigger,
	input wire logic trough_adc_trigger,
	input wire logic running,
	// pins
	input wire logic carrier_sync_toggle_out,
	input wire logic phase1_positive_out,
	input wire logic phase1_inverse_out,
	input wire logic phase2_positive_out,
	input wire logic phase2_inverse_out,
	input wire logic phase3_positive_out,
	input wire logic phase3_inverse_out
);
	// on state of each line, phase one in bit 0
	logic [2:0] pos_on;
	logic [2:0] inv_on;
	assign pos_on = {phase3_positive_out, phase2_positive_out, phase1_positive_out}
		~^ {3{positive_level_select}};
	assign inv_on = {phase3_inverse_out, phase2_inverse_out, phase1_inverse_out}
		~^ {3{negative_level_select}};
	// single domain: one clock, one reset for everything below
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// stopped: every line off; guarded because pins lag a level change by a cycle
	property p_idle_off;
		!running && !$past(running) && $stable(positive_level_select)
			&& $stable(negative_level_select) |-> (pos_on | inv_on) == 3'h0;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("line on while stopped");
	// a leg must never have both switches on
	property p_no_overlap;
		running |-> (pos_on & inv_on) == 3'h0;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("pair both on");
	// without gap exactly one line of each pair is on
	property p_nogap;
		running && $past(running) && !dead_time_en && !$past(dead_time_en)
			|-> (pos_on ^ inv_on) == 3'h7;
	endproperty
	a_nogap: assert property (p_nogap) else $error("pair not complementary");
	// a turning point shows up as a toggle of the sync line
	property p_sync_ev;
		(crest_event || trough_event) && carrier_sync_en && $past(carrier_sync_en, 2)
			|-> carrier_sync_toggle_out != $past(carrier_sync_toggle_out, 2);
	endproperty
	a_sync_ev: assert property (p_sync_ev) else $error("sync did not toggle");
	// disabled sync line holds still while counting
	property p_sync_hold;
		running && $past(running) && !carrier_sync_en && !$past(carrier_sync_en)
			|-> $stable(carrier_sync_toggle_out);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync moved while off");
	// start goes through one load cycle before counting
	property p_start;
		$rose(run_en) && !running |-> ##1 !running ##1 running;
	endproperty
	a_start: assert property (p_start) else $error("start sequence wrong");
	// sync line starts every run at one
	property p_sync_init;
		$rose(running) |-> carrier_sync_toggle_out;
	endproperty
	a_sync_init: assert property (p_sync_init) else $error("sync not preset");
	// stop: idle next cycle, lines off the cycle after
	property p_stop;
		running && !run_en |=> !running ##1 ((pos_on | inv_on) == 3'h0);
	endproperty
	a_stop: assert property (p_stop) else $error("stop sequence wrong");
	// no turning point events once counting has stopped
	property p_ev_idle;
		!running && !$past(running) && !$past(running, 2) |-> !crest_event && !trough_event;
	endproperty
	a_ev_idle: assert property (p_ev_idle) else $error("event while stopped");
	// converter start triggers are skipped together with their events
	property p_adc_trig;
		crest_adc_trigger == crest_event && trough_adc_trigger == trough_event;
	endproperty
	a_adc_trig: assert property (p_adc_trig) else $error("trigger apart from event");
endmodule // ctp_pwm_chk

// ### dv/ctp_gate_drv_model.sv
// gate driver model: tallies shoot-through, dead cycles and phase one edges
`timescale 1ns/100ps
module ctp_gate_drv_model (
	// clock and tally clear
	input wire logic mclk,
	input wire logic clr,
	// active levels of the pins
	input wire logic pos_level,
	input wire logic neg_level,
	// pins, phase one in bit 0
	input wire logic [2:0] pos_pin,
	input wire logic [2:0] inv_pin,
	// tallies
	output int shoot,
	output int dead,
	output int edges
);
	logic [2:0] pon;
	logic [2:0] ion;
	logic p1_last;
	assign pon = pos_pin ~^ {3{pos_level}};
	assign ion = inv_pin ~^ {3{neg_level}};
	// a switch pair both on would short the leg, so it is counted, not tolerated
	always @(posedge mclk) begin
		p1_last <= pos_pin[0];
		if (clr) begin
			shoot <= 0;
			dead <= 0;
			edges <= 0;
		end else begin
			if ((pon & ion) != 3'h0) shoot <= shoot + 1;
			if ((pon | ion) != 3'h7) dead <= dead + 1;
			if (pos_pin[0] != p1_last) edges <= edges + 1;
		end
	end
endmodule // ctp_gate_drv_model

// ### dv/tb.sv
// self-checking testbench for the complementary three-phase pwm generator
`timescale 1ns/100ps
module tb;
	// design inputs
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic run_en = 1'b0;
	logic dead_time_en = 1'b1;
	logic positive_level_select = 1'b0;
	logic negative_level_select = 1'b0;
	logic carrier_sync_en = 1'b1;
	logic [2:0] clock_select = 3'h0;
	logic [2:0] event_skip = 3'h0;
	logic [1:0] external_clock_in = 2'h0;
	// design outputs
	logic [15:0] reg_rdata;
	logic crest_event;
	logic trough_event;
	logic running;
	logic carrier_sync_toggle_out;
	wire [2:0] pos;
	wire [2:0] inv;
	// bench state
	logic ext_on = 1'b0;
	logic clr = 1'b1;
	int ext_cnt = 0;
	int cyc = 0;
	int num_errors = 0;
	int n_compared = 0;
	int shoot;
	int dead;
	int edges;
	int n;
	ctp_pwm ctp_pwm_i (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.run_en, .dead_time_en, .positive_level_select, .negative_level_select,
		.carrier_sync_en, .clock_select, .event_skip, .external_clock_in, .crest_event,
		.trough_event, .crest_adc_trigger(), .trough_adc_trigger(), .running,
		.carrier_sync_toggle_out, .phase1_positive_out(pos[0]), .phase1_inverse_out(inv[0]),
		.phase2_positive_out(pos[1]), .phase2_inverse_out(inv[1]),
		.phase3_positive_out(pos[2]), .phase3_inverse_out(inv[2]));
	ctp_gate_drv_model ctp_gate_drv_model_i (.mclk, .clr, .pos_level(positive_level_select),
		.neg_level(negative_level_select), .pos_pin(pos), .inv_pin(inv), .shoot, .dead,
		.edges);
	// 100 mhz clock
	always #5 mclk = ~mclk;
	// external clock pins toggle every third cycle; ceiling on run length
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
		if (ext_on && ext_cnt == 2) external_clock_in <= ~external_clock_in;
		if (cyc == 60000) begin
			num_errors = num_errors + 1;
			complete_run;
		end
	end
	// compare one result
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one register write, strobe dropped one edge later
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// one register read; data is registered at the read edge
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// cycles up to the next crest or trough pulse, bounded
	task automatic wait_ev(input logic crest, output int k);
		k = 0;
		do begin
			@(posedge mclk);
			#1 k++;
		end while (!(crest ? crest_event : trough_event) && k < 20000);
	endtask
	// stop, then program limits and all duties; phase three buffer goes last
	task automatic cfg(input logic [15:0] d, input logic [15:0] h, input logic [15:0] du);
		@(posedge mclk);
		run_en <= 1'b0;
		carrier_sync_en <= 1'b1;
		event_skip <= 3'h0;
		repeat (3) @(posedge mclk);
		wr(ctp_pkg::IDX_DEAD_TIME_VALUE, d);
		wr(ctp_pkg::IDX_HALF_CYCLE_VALUE, h);
		wr(ctp_pkg::IDX_HALF_CYCLE_BUFFER, h);
		wr(ctp_pkg::IDX_UPPER_LIMIT_COMPARE, h + d);
		wr(ctp_pkg::IDX_UPPER_LIMIT_BUFFER, h + d);
		for (int i = 1; i < 8; i++) begin
			if (i != 2) wr(4'(i), du);
		end
	endtask
	// set source, levels and gap mode while stopped, then start
	task automatic go(input logic [2:0] s, input logic lvl, input logic gap);
		@(posedge mclk);
		clock_select <= s;
		positive_level_select <= lvl;
		negative_level_select <= lvl;
		dead_time_en <= gap;
		repeat (3) @(posedge mclk);
		run_en <= 1'b1;
	endtask
	// reset values, plain access, unmapped places
	task automatic t_regs;
		for (int i = 0; i < 16; i++) begin
			rd(4'(i), (i < 8 || (i > 9 && i < 13)) ? ctp_pkg::RST_REG : 16'h0000);
		end
		wr(ctp_pkg::IDX_DEAD_TIME_VALUE, 16'h1234);
		rd(ctp_pkg::IDX_DEAD_TIME_VALUE, 16'h1234);
		wr(4'hd, 16'h0005);
		rd(4'hd, 16'h0000);
	endtask
	// preload and refused direct writes with the counter held, then buffered transfers
	task automatic t_start;
		cfg(16'h0002, 16'h0004, 16'h0003);
		carrier_sync_en <= 1'b0;
		go(3'h6, 1'b0, 1'b1);
		repeat (4) @(posedge mclk);
		rd(ctp_pkg::IDX_UPPER_COUNTER, 16'h0002);
		rd(ctp_pkg::IDX_LOWER_COUNTER, 16'h0000);
		wr(ctp_pkg::IDX_UPPER_LIMIT_COMPARE, 16'h0050);
		rd(ctp_pkg::IDX_UPPER_LIMIT_COMPARE, 16'h0006);
		wr(ctp_pkg::IDX_PHASE1_DUTY_COMPARE, 16'h0009);
		rd(ctp_pkg::IDX_PHASE1_DUTY_COMPARE, 16'h0003);
		wr(ctp_pkg::IDX_PHASE1_DUTY_BUFFER, 16'h0005);
		wr(ctp_pkg::IDX_UPPER_LIMIT_BUFFER, 16'h0007);
		wr(ctp_pkg::IDX_HALF_CYCLE_BUFFER, 16'h0005);
		ext_on <= 1'b1;
		wait_ev(1'b1, n);
		rd(ctp_pkg::IDX_UPPER_LIMIT_COMPARE, 16'h0007);
		rd(ctp_pkg::IDX_HALF_CYCLE_VALUE, 16'h0005);
		rd(ctp_pkg::IDX_PHASE1_DUTY_COMPARE, 16'h0003);
		wr(ctp_pkg::IDX_PHASE3_DUTY_BUFFER, 16'h0002);
		wait_ev(1'b0, n);
		rd(ctp_pkg::IDX_PHASE1_DUTY_COMPARE, 16'h0005);
		rd(ctp_pkg::IDX_PHASE2_DUTY_COMPARE, 16'h0003);
		rd(ctp_pkg::IDX_PHASE3_DUTY_COMPARE, 16'h0002);
	endtask
	// every clock source: half period is four ticks of the chosen source
	task automatic t_clocks;
		int dv;
		for (int s = 0; s < 8; s++) begin
			dv = (s < 6) ? (1 << (2 * s)) : 6;
			cfg(16'h0002, 16'h0004, 16'h0003);
			go(3'(s), 1'b0, 1'b1);
			wait_ev(1'b1, n);
			wait_ev(1'b0, n);
			chk(16'(n), 16'(4 * dv));
			wait_ev(1'b1, n);
			chk(16'(n), 16'(4 * dv));
		end
		cfg(16'h0002, 16'h0004, 16'h0003);
		event_skip <= 3'h2;
		go(3'h0, 1'b0, 1'b1);
		wait_ev(1'b1, n);
		wait_ev(1'b1, n);
		chk(16'(n), 16'h0018);
	endtask
	// one carrier period of a given duty and mode, tallied by the driver model
	task automatic pin_run(input logic [15:0] du, input logic lvl, input logic gap);
		cfg(16'h0002, 16'h0008, du);
		go(3'h0, lvl, gap);
		wait_ev(1'b1, n);
		clr <= 1'b0;
		wait_ev(1'b1, n);
		clr <= 1'b1;
	endtask
	// fixed levels at the duty extremes, switching and gaps in between
	task automatic t_pins;
		for (int l = 0; l < 2; l++) begin
			pin_run(16'h0000, l[0], 1'b1);
			chk(16'({pos, inv}), 16'({{3{l[0]}}, {3{!l[0]}}}));
			pin_run(16'hffff, l[0], 1'b1);
			chk(16'({pos, inv}), 16'({{3{!l[0]}}, {3{l[0]}}}));
			pin_run(16'h0006, l[0], 1'b1);
			chk(16'(edges), 16'h0002);
			chk(16'(shoot), 16'h0000);
			chk(16'(dead > 0), 16'h0001);
			pin_run(16'h0006, l[0], 1'b0);
			chk(16'(dead), 16'h0000);
		end
	endtask
	// counts, verdict and end of run
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_regs;
		t_start;
		t_clocks;
		t_pins;
		complete_run;
	end
endmodule // tb
bind ctp_pwm ctp_pwm_chk ctp_pwm_chk_i (.mclk, .rst, .run_en, .dead_time_en,
	.positive_level_select, .negative_level_select, .carrier_sync_en, .crest_event,
	.trough_event, .crest_adc_trigger, .trough_adc_trigger, .running,
	.carrier_sync_toggle_out, .phase1_positive_out,
	.phase1_inverse_out, .phase2_positive_out, .phase2_inverse_out, .phase3_positive_out,
	.phase3_inverse_out);
